//--- hdl/bsx_exec.sv
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// Behaviour
// [RL1] push writes source to stack, two cycles
// [RL2] pop loads destination from stack, two cycles
// [RL3] io bit set, others kept, two cycles
// [RL4] io bit clear, others kept, two cycles
// [RL5] left shift, zero fill, flags updated
// [RL6] right shift, zero fill, flags updated
// [RL7] rotate left through carry, flags updated
// [RL8] rotate right through carry, flags updated
// [RL9] nibble swap, flags unchanged, one cycle
// [RL10] register bit copied into T only
// [RL11] T copied into register bit
// [RL12] set/clear C, N, Z, S singly
// [RL13] set/clear V and T singly
// [RL14] clear half carry only
// [RL15] sleep one cycle, pulses sleep request
// [RL16] watchdog restart one cycle, pulses restart
// [RL17] break only signals debug, no flags
// [RL18] arithmetic right shift keeps bit 7
// [RL19] generic set/clear by three-bit index
// [RL20] interrupt enable/disable sets/clears I
// [RL21] idle cycle changes nothing
module bsx_exec
   import bsx_pkg::*;
#(
   parameter int STACK_DEPTH = 16
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             sleep_req,
   output logic             wdog_restart,
   output logic             debug_break
);
   localparam int SPW = $clog2(STACK_DEPTH);

   typedef struct packed {
      bsx_state_type state;
      bsx_op_type    op;
      logic [1:0]    cnt;
      logic [2:0]    bit_sel;
      logic [7:0]    operand;
      logic [7:0]    flags;
      logic [7:0]    result;
      logic [7:0]    ioreg;
      logic [SPW-1:0] sp;
      logic [31:0]   rdata;
      logic          ready;
      logic          err;
      logic          sleep;
      logic          wdog;
      logic          brk;
   } bsx_regs_type;

   bsx_regs_type r_q;
   bsx_regs_type r_d;
   logic [7:0] stack_q [STACK_DEPTH];
   logic       stack_we;
   logic [7:0] shift_res;
   logic [7:0] shift_flags;
   logic [7:0] flag_flags;
   logic       wr_acc;
   logic       rd_acc;

   function automatic logic known_addr(input logic [11:0] a);
      return a inside {OFS_CMD, OFS_OPND, OFS_FLAGS, OFS_RESULT,
                       OFS_STATUS, OFS_SPTR, OFS_IOREG, OFS_EVENTS};
   endfunction

   bsx_shift u_shift (
      .op        (r_q.op),
      .value     (r_q.operand),
      .bit_sel   (r_q.bit_sel),
      .flags_in  (r_q.flags),
      .result    (shift_res),
      .flags_out (shift_flags)
   );

   bsx_flags u_flags (
      .op        (r_q.op),
      .bit_sel   (r_q.bit_sel),
      .flags_in  (r_q.flags),
      .flags_out (flag_flags)
   );

   assign wr_acc   = psel && penable && !r_q.ready && pwrite;
   assign rd_acc   = psel && penable && !r_q.ready && !pwrite;
   assign stack_we = (r_q.state == ST_TWO) && (r_q.op == OP_PUSH) && (r_q.cnt == CYC_ONE);

   always_comb begin
      r_d       = r_q;
      r_d.ready = 1'b0;
      r_d.err   = 1'b0;
      r_d.sleep = 1'b0;
      r_d.wdog  = 1'b0;
      r_d.brk   = 1'b0;

      // apb slave, one wait state
      if (psel && penable && !r_q.ready) begin
         r_d.ready = 1'b1;
         r_d.err   = !known_addr(paddr) || (wr_acc && r_q.state != ST_IDLE
                     && paddr == OFS_CMD);
         r_d.rdata = 32'h0000_0000;
         case (paddr)
            OFS_CMD:    r_d.rdata = {13'h0, r_q.bit_sel, 3'h0, 5'(r_q.op), 6'h0, 2'(r_q.state)};
            OFS_OPND:   r_d.rdata = {24'h0, r_q.operand};
            OFS_FLAGS:  r_d.rdata = {24'h0, r_q.flags};
            OFS_RESULT: r_d.rdata = {24'h0, r_q.result};
            OFS_STATUS: r_d.rdata = {30'h0, r_q.state != ST_IDLE, r_q.state == ST_IDLE};
            OFS_SPTR:   r_d.rdata = {{(32-SPW){1'b0}}, r_q.sp};
            OFS_IOREG:  r_d.rdata = {24'h0, r_q.ioreg};
            default:    r_d.rdata = 32'h0000_0000;
         endcase
      end

      if (wr_acc && r_q.state == ST_IDLE) begin
         case (paddr)
            OFS_OPND:  r_d.operand = pwdata[7:0];
            OFS_FLAGS: r_d.flags   = pwdata[7:0];
            OFS_IOREG: r_d.ioreg   = pwdata[7:0];
            OFS_CMD: begin
               r_d.op      = bsx_op_type'(pwdata[12:8]);
               r_d.bit_sel = pwdata[18:16];
               r_d.state   = ST_EXEC;
               r_d.cnt     = CYC_ONE;
            end
            default: r_d.operand = r_q.operand;
         endcase
      end

      case (r_q.state)
         ST_IDLE: r_d.cnt = r_q.cnt;
         ST_EXEC: begin
            r_d.state = ST_IDLE;
            case (r_q.op)
               OP_PUSH, OP_POP, OP_IO_SET, OP_IO_CLR: begin
                  r_d.state = ST_TWO;                              // [RL1] [RL2] [RL3] [RL4]
                  r_d.cnt   = CYC_ONE;
               end
               OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT, OP_ARITH_RIGHT,
               OP_SWAP, OP_BIT_TO_T, OP_T_TO_BIT: begin
                  r_d.result = shift_res;                          // [RL5] [RL6] [RL7] [RL8]
                  r_d.flags  = shift_flags;                        // [RL9] [RL10] [RL11] [RL18]
               end
               OP_FSET, OP_FCLR: r_d.flags = flag_flags;           // [RL12] [RL13] [RL14] [RL19] [RL20]
               OP_SLEEP: r_d.sleep = 1'b1;                         // [RL15]
               OP_WDOG:  r_d.wdog  = 1'b1;                         // [RL16]
               OP_BREAK: r_d.brk   = 1'b1;                         // [RL17]
               default:  r_d.flags = r_q.flags;                    // [RL21]
            endcase
         end
         ST_TWO: begin
            r_d.state = ST_IDLE;
            case (r_q.op)
               OP_PUSH: r_d.sp = r_q.sp - SPW'(1);                 // [RL1]
               OP_POP: begin
                  r_d.sp     = r_q.sp + SPW'(1);
                  r_d.result = stack_q[SPW'(r_q.sp + SPW'(1))];    // [RL2]
               end
               OP_IO_SET: r_d.ioreg[r_q.bit_sel] = 1'b1;           // [RL3]
               OP_IO_CLR: r_d.ioreg[r_q.bit_sel] = 1'b0;           // [RL4]
               default: r_d.sp = r_q.sp;
            endcase
         end
         default: r_d.state = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q         <= '0;
         r_q.state   <= ST_IDLE;
         r_q.op      <= OP_IDLE;
         r_q.flags   <= RST_FLAGS;
         r_q.operand <= RST_BYTE;
         r_q.result  <= RST_BYTE;
         r_q.ioreg   <= RST_BYTE;
         r_q.sp      <= SPW'(RST_SPTR);
      end else begin
         r_q <= r_d;
      end
   end

   always_ff @(posedge pclk) begin
      if (stack_we) begin
         stack_q[r_q.sp] <= r_q.operand;                           // [RL1]
      end
   end

   assign prdata       = r_q.rdata;
   assign pready       = r_q.ready;
   assign pslverr      = r_q.err;
   assign sleep_req    = r_q.sleep;
   assign wdog_restart = r_q.wdog;
   assign debug_break  = r_q.brk;
endmodule // bsx_exec

//--- hdl/bsx_flags.sv
`timescale 1ns/1ps
module bsx_flags
   import bsx_pkg::*;
(
   input  wire bsx_op_type op,
   input  wire logic [2:0] bit_sel,
   input  wire logic [7:0] flags_in,
   output logic      [7:0] flags_out
);
   // named flag ops (set carry, clear half carry, irq enable...) are issued
   // as the generic form with the flag index in bit_sel
   always_comb begin
      flags_out = flags_in;
      case (op)
         OP_FSET: flags_out[bit_sel] = 1'b1;  // [RL12] [RL13] [RL19] [RL20]
         OP_FCLR: flags_out[bit_sel] = 1'b0;  // [RL12] [RL13] [RL14] [RL19] [RL20]
         default: flags_out = flags_in;
      endcase
   end
endmodule // bsx_flags

//--- hdl/bsx_pkg.sv
package bsx_pkg;

   // status flag positions
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned FLAG_V = 3;
   localparam int unsigned FLAG_S = 4;
   localparam int unsigned FLAG_H = 5;
   localparam int unsigned FLAG_T = 6;
   localparam int unsigned FLAG_I = 7;

   // register byte offsets
   localparam logic [11:0] OFS_CMD    = 12'h000;
   localparam logic [11:0] OFS_OPND   = 12'h004;
   localparam logic [11:0] OFS_FLAGS  = 12'h008;
   localparam logic [11:0] OFS_RESULT = 12'h00C;
   localparam logic [11:0] OFS_STATUS = 12'h010;
   localparam logic [11:0] OFS_SPTR   = 12'h014;
   localparam logic [11:0] OFS_IOREG  = 12'h018;
   localparam logic [11:0] OFS_EVENTS = 12'h01C;

   // reset values
   localparam logic [7:0] RST_FLAGS  = 8'h00;
   localparam logic [7:0] RST_SPTR   = 8'hFF;
   localparam logic [7:0] RST_BYTE   = 8'h00;

   // cycle counts
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;

   typedef enum logic [4:0] {
      OP_IDLE       = 5'h00,
      OP_PUSH       = 5'h01,
      OP_POP        = 5'h02,
      OP_IO_SET     = 5'h03,
      OP_IO_CLR     = 5'h04,
      OP_SHIFT_LEFT  = 5'h05,
      OP_SHIFT_RIGHT = 5'h06,
      OP_ROT_LEFT    = 5'h07,
      OP_ROT_RIGHT   = 5'h08,
      OP_ARITH_RIGHT = 5'h09,
      OP_SWAP       = 5'h0A,
      OP_FSET       = 5'h0B,
      OP_FCLR       = 5'h0C,
      OP_BIT_TO_T   = 5'h0D,
      OP_T_TO_BIT   = 5'h0E,
      OP_SLEEP      = 5'h0F,
      OP_WDOG       = 5'h10,
      OP_BREAK      = 5'h11
   } bsx_op_type;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_EXEC  = 2'b01,
      ST_TWO   = 2'b10
   } bsx_state_type;

endpackage

//--- hdl/bsx_shift.sv
`timescale 1ns/1ps
module bsx_shift
   import bsx_pkg::*;
(
   input  wire bsx_op_type op,
   input  wire logic [7:0] value,
   input  wire logic [2:0] bit_sel,
   input  wire logic [7:0] flags_in,
   output logic      [7:0] result,
   output logic      [7:0] flags_out
);
   logic c_new;
   logic n_new;
   logic v_new;

   always_comb begin
      result    = value;
      flags_out = flags_in;
      c_new     = flags_in[FLAG_C];
      case (op)
         OP_SHIFT_LEFT: begin
            result = {value[6:0], 1'b0};                   // [RL5]
            c_new  = value[7];
         end
         OP_SHIFT_RIGHT: begin
            result = {1'b0, value[7:1]};                   // [RL6]
            c_new  = value[0];
         end
         OP_ROT_LEFT: begin
            result = {value[6:0], flags_in[FLAG_C]};       // [RL7]
            c_new  = value[7];
         end
         OP_ROT_RIGHT: begin
            result = {flags_in[FLAG_C], value[7:1]};       // [RL8]
            c_new  = value[0];
         end
         OP_ARITH_RIGHT: begin
            result = {value[7], value[7:1]};               // [RL18]
            c_new  = value[0];
         end
         OP_SWAP: result = {value[3:0], value[7:4]};       // [RL9]
         OP_BIT_TO_T: flags_out[FLAG_T] = value[bit_sel];  // [RL10]
         OP_T_TO_BIT: result[bit_sel] = flags_in[FLAG_T];  // [RL11]
         default: result = value;
      endcase
      n_new = result[7];
      v_new = n_new ^ c_new;
      if (op inside {OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT,
                     OP_ARITH_RIGHT}) begin
         flags_out[FLAG_C] = c_new;
         flags_out[FLAG_Z] = (result == 8'h00);
         flags_out[FLAG_N] = n_new;
         flags_out[FLAG_V] = v_new;
         flags_out[FLAG_S] = n_new ^ v_new;
      end
   end
endmodule // bsx_shift

//--- test/bsx_exec_props.sv
`timescale 1ns/1ps
module bsx_exec_props
   import bsx_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sleep_req,
   input wire logic        wdog_restart,
   input wire logic        debug_break
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic cmd;
   assign cmd = psel && penable && pready && pwrite && paddr == OFS_CMD && !pslverr;
   AST_ANSWER: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered");
   AST_PULSE: assert property (pready |-> psel && penable ##1 !pready)
      else $error("answer outside access");
   AST_UNMAPPED: assert property (pready && paddr > OFS_EVENTS |-> pslverr && prdata == 0)
      else $error("unmapped access accepted");
   AST_SLEEP: assert property (cmd && pwdata[12:8] == OP_SLEEP |-> ##[1:3] sleep_req)
      else $error("sleep not requested");
   AST_SLEEP_ONE: assert property (sleep_req |=> !sleep_req)
      else $error("sleep request too long");
   AST_WDOG: assert property (cmd && pwdata[12:8] == OP_WDOG |-> ##[1:3] wdog_restart)
      else $error("watchdog not restarted");
   AST_WDOG_ONE: assert property ($rose(wdog_restart) |=> $fell(wdog_restart))
      else $error("restart too long");
   AST_BREAK: assert property (cmd && pwdata[12:8] == OP_BREAK |-> ##[1:3] debug_break)
      else $error("break not signalled");
   AST_IDLE: assert property (cmd && pwdata[12:8] == OP_IDLE |=>
      !(sleep_req || wdog_restart || debug_break) [*3])
      else $error("idle cycle had effect");
   COV_SLEEP: cover property (sleep_req);
   COV_ERR: cover property (pready && pslverr);
   COV_BREAK: cover property (debug_break);
endmodule // bsx_exec_props
bind bsx_exec bsx_exec_props bsx_exec_props_inst (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_req, .wdog_restart,
   .debug_break);

//--- test/bsx_seq_model.sv
`timescale 1ns/1ps
module bsx_seq_model
   import bsx_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // one apb transfer, held until pready
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
endmodule // bsx_seq_model

//--- test/test_bit_shift_flag_exec_unit.sv
`timescale 1ns/1ps
module test_bit_shift_flag_exec_unit;
   import bsx_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic        e;
   logic        sleep_req, wdog_restart, debug_break;
   int          n_sleep = 0;
   int          n_wdog = 0;
   int          n_brk = 0;
   int          errors = 0;
   int          cmp_count = 0;
   initial forever #5 pclk = ~pclk;
   bsx_exec bsx_exec_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sleep_req, .wdog_restart, .debug_break);
   // count the cycles each event pulse stands high
   always @(posedge pclk) begin
      if (sleep_req === 1'b1)
         n_sleep <= n_sleep + 1;
      if (wdog_restart === 1'b1)
         n_wdog <= n_wdog + 1;
      if (debug_break === 1'b1)
         n_brk <= n_brk + 1;
   end
   bsx_seq_model bsx_seq_model_inst (.pclk, .prdata, .pready, .pslverr, .psel, .penable,
      .pwrite, .paddr, .pwdata);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bsx_seq_model_inst.xfer(1'b1, a, {24'h0, d}, r, e);
   endtask
   task automatic rc(input logic [11:0] a, input logic [7:0] x);
      bsx_seq_model_inst.xfer(1'b0, a, 32'h0, r, e);
      chk(r, {24'h0, x});
   endtask
   task automatic op(input logic [4:0] o, input logic [2:0] b);
      bsx_seq_model_inst.xfer(1'b1, OFS_CMD, {13'h0, b, 3'h0, o, 8'h0}, r, e);
      r = 0;
      while (r[0] !== 1'b1) bsx_seq_model_inst.xfer(1'b0, OFS_STATUS, 32'h0, r, e);
   endtask
   task automatic t_shift();
      bsx_op_type ops [5] = '{OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT,
                              OP_ARITH_RIGHT};
      logic [7:0] v, x, f;
      logic c;
      for (int i = 0; i < 10; i++) begin
         v = i[0] ? 8'h80 : 8'h41;
         f = i[0] ? 8'hE0 : 8'h01;
         case (ops[i / 2])
            OP_SHIFT_LEFT: {c, x} = {v, 1'b0};
            OP_SHIFT_RIGHT: {x, c} = {1'b0, v};
            OP_ROT_LEFT: {c, x} = {v, f[0]};
            OP_ROT_RIGHT: {x, c} = {f[0], v};
            default: {x, c} = {v[7], v};
         endcase
         wr(OFS_OPND, v);
         wr(OFS_FLAGS, f);
         op(ops[i / 2], 3'h0);
         rc(OFS_RESULT, x);
         rc(OFS_FLAGS, {f[7:5], c, x[7] ^ c, x[7], x == 0, c});
      end
   endtask
   task automatic t_misc();
      logic [7:0] s;
      for (int i = 0; i < 8; i++) begin
         wr(OFS_FLAGS, 8'h5A);
         op(OP_FSET, i[2:0]);
         rc(OFS_FLAGS, 8'h5A | (8'h01 << i));
         op(OP_FCLR, i[2:0]);
         rc(OFS_FLAGS, 8'h5A & ~(8'h01 << i));
      end
      wr(OFS_OPND, 8'h3C);
      op(OP_SWAP, 3'h0);
      rc(OFS_RESULT, 8'hC3);
      wr(OFS_FLAGS, 8'h00);
      wr(OFS_OPND, 8'h04);
      op(OP_BIT_TO_T, 3'h2);
      rc(OFS_FLAGS, 8'h40);
      wr(OFS_OPND, 8'h00);
      op(OP_T_TO_BIT, 3'h5);
      rc(OFS_RESULT, 8'h20);
      bsx_seq_model_inst.xfer(1'b0, OFS_SPTR, 32'h0, r, e);
      s = r[7:0];
      chk(r, 32'h0000_000F);
      wr(OFS_OPND, 8'hA5);
      op(OP_PUSH, 3'h0);
      rc(OFS_SPTR, s - 8'h01);
      wr(OFS_OPND, 8'h00);
      op(OP_POP, 3'h0);
      rc(OFS_RESULT, 8'hA5);
      rc(OFS_SPTR, s);
      wr(OFS_IOREG, 8'h81);
      op(OP_IO_SET, 3'h3);
      rc(OFS_IOREG, 8'h89);
      op(OP_IO_CLR, 3'h7);
      rc(OFS_IOREG, 8'h09);
      bsx_seq_model_inst.xfer(1'b0, OFS_CMD, 32'h0, r, e);
      chk(r, {13'h0, 3'h7, 3'h0, 5'(OP_IO_CLR), 8'h00});
      op(OP_IDLE, 3'h0);
      chk(32'(n_sleep + n_wdog + n_brk), 32'h0);
      op(OP_SLEEP, 3'h0);
      chk(32'(n_sleep), 32'h1);
      op(OP_WDOG, 3'h0);
      chk(32'(n_wdog), 32'h1);
      op(OP_BREAK, 3'h0);
      chk(32'(n_brk), 32'h1);
      rc(OFS_FLAGS, 8'h40);
      bsx_seq_model_inst.xfer(1'b0, 12'h020, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
   endtask
   task automatic complete_run();
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rc(OFS_FLAGS, RST_FLAGS);
      t_shift();
      t_misc();
      complete_run();
   end
   initial begin
      #200000;
      errors++;
      complete_run();
   end
endmodule // test_bit_shift_flag_exec_unit
